// ==== dbpm_pkg.sv ====
// Constants for the dual byte-wide port and bus mux.
// Assumes a 32-bit APB slave; register byte address is four times its index.
package dbpm_pkg;
   // Register indices and derived byte addresses
   localparam logic [15:0] UPPER_DIR_IDX   = 16'hfe80;
   localparam logic [15:0] LOWER_DIR_IDX   = 16'hfe81;
   localparam logic [15:0] UPPER_LATCH_IDX = 16'hfe82;
   localparam logic [15:0] LOWER_LATCH_IDX = 16'hfe83;
   localparam int          ADDR_W          = 18;
   localparam logic [17:0] UPPER_DIR_ADDR   = {UPPER_DIR_IDX, 2'b00};
   localparam logic [17:0] LOWER_DIR_ADDR   = {LOWER_DIR_IDX, 2'b00};
   localparam logic [17:0] UPPER_LATCH_ADDR = {UPPER_LATCH_IDX, 2'b00};
   localparam logic [17:0] LOWER_LATCH_ADDR = {LOWER_LATCH_IDX, 2'b00};
   // Reset values and read-back constants
   localparam logic [7:0]  DIR_RESET   = 8'h00;
   localparam logic [7:0]  LATCH_RESET = 8'h00;
   localparam logic [7:0]  READ_ONES   = 8'hff;
   // Operating modes
   localparam logic [2:0]  MODE_MIN2   = 3'h2;
   localparam logic [2:0]  MODE_SINGLE = 3'h7;
endpackage

// ==== dbpm_port.sv ====
// Two 8-bit pin ports muxed between general-purpose I/O and the external data bus.
// Assumes an APB master on pclk, mode and standby pins from outside the clock domain,
// and an external bus controller on pclk that flags write cycles.
//
// Decided for this implementation: register access over APB.
`timescale 1ns/1ps
module dbpm_port (
   // APB clock and reset
   input  wire logic        pclk,
   input  wire logic        presetn,
   // APB slave
   input  wire logic        psel,
   input  wire logic        penable,
   input  wire logic        pwrite,
   input  wire logic [17:0] paddr,
   input  wire logic [31:0] pwdata,
   output logic             pready,
   output logic [31:0]      prdata,
   output logic             pslverr,
   // Chip state pins and CPU standby level
   input  wire logic [2:0]  mode_pins,
   input  wire logic        hw_standby,
   input  wire logic        sw_standby,
   // External bus controller
   input  wire logic        bus_write_cycle,
   input  wire logic [15:0] bus_wdata,
   output logic [15:0]      bus_rdata,
   // Upper port pins
   input  wire logic [7:0]  upper_pin_in,
   output logic [7:0]       upper_pin_out,
   output logic [7:0]       upper_pin_oe,
   // Lower port pins
   input  wire logic [7:0]  lower_pin_in,
   output logic [7:0]       lower_pin_out,
   output logic [7:0]       lower_pin_oe
);

   ////////////////////////////////////////////////////////////////////////////
   // Input synchronisers
   logic [2:0]  mode_s1_reg,  mode_reg;
   logic        hws_s1_reg,   hws_reg;
   logic [7:0]  up_s1_reg,    up_sync_reg;
   logic [7:0]  lo_s1_reg,    lo_sync_reg;

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         mode_s1_reg <= dbpm_pkg::MODE_SINGLE;
         mode_reg    <= dbpm_pkg::MODE_SINGLE;
         hws_s1_reg  <= 1'b0;
         hws_reg     <= 1'b0;
         up_s1_reg   <= 8'h00;
         up_sync_reg <= 8'h00;
         lo_s1_reg   <= 8'h00;
         lo_sync_reg <= 8'h00;
      end else begin
         mode_s1_reg <= mode_pins;
         mode_reg    <= mode_s1_reg;
         hws_s1_reg  <= hw_standby;
         hws_reg     <= hws_s1_reg;
         up_s1_reg   <= upper_pin_in;
         up_sync_reg <= up_s1_reg;
         lo_s1_reg   <= lower_pin_in;
         lo_sync_reg <= lo_s1_reg;
      end
   end

   ////////////////////////////////////////////////////////////////////////////
   // Mode decode
   wire upper_bus = (mode_reg != dbpm_pkg::MODE_SINGLE);
   wire lower_bus = upper_bus && (mode_reg != dbpm_pkg::MODE_MIN2);

   ////////////////////////////////////////////////////////////////////////////
   // APB decode
   wire       acc_phase = psel && penable;
   wire       wr_take   = acc_phase && pready && pwrite;
   wire       rd_capture = acc_phase && !pready && !pwrite;
   wire       hit_udir  = (paddr == dbpm_pkg::UPPER_DIR_ADDR);
   wire       hit_ldir  = (paddr == dbpm_pkg::LOWER_DIR_ADDR);
   wire       hit_ulat  = (paddr == dbpm_pkg::UPPER_LATCH_ADDR);
   wire       hit_llat  = (paddr == dbpm_pkg::LOWER_LATCH_ADDR);
   wire       mapped    = hit_udir || hit_ldir || hit_ulat || hit_llat;

   ////////////////////////////////////////////////////////////////////////////
   // Port registers
   logic [7:0] udir_reg, ldir_reg, ulat_reg, llat_reg;
   logic [7:0] udir_next, ldir_next, ulat_next, llat_next;

   // Hardware standby clears; software standby has no term here at all
   assign udir_next = hws_reg ? dbpm_pkg::DIR_RESET :
                      (wr_take && hit_udir) ? pwdata[7:0] : udir_reg;
   assign ldir_next = hws_reg ? dbpm_pkg::DIR_RESET :
                      (wr_take && hit_ldir) ? pwdata[7:0] : ldir_reg;
   // Latch takes writes in GPIO mode whatever the direction
   assign ulat_next = hws_reg ? dbpm_pkg::LATCH_RESET :
                      (wr_take && hit_ulat && !upper_bus) ? pwdata[7:0] : ulat_reg;
   assign llat_next = hws_reg ? dbpm_pkg::LATCH_RESET :
                      (wr_take && hit_llat && !lower_bus) ? pwdata[7:0] : llat_reg;

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         udir_reg <= dbpm_pkg::DIR_RESET;
         ldir_reg <= dbpm_pkg::DIR_RESET;
         ulat_reg <= dbpm_pkg::LATCH_RESET;
         llat_reg <= dbpm_pkg::LATCH_RESET;
      end else begin
         udir_reg <= udir_next;
         ldir_reg <= ldir_next;
         ulat_reg <= ulat_next;
         llat_reg <= llat_next;
      end
   end

   ////////////////////////////////////////////////////////////////////////////
   // Read data: direction and bus-mode latch reads give all ones; in GPIO mode output pins show the latch, input pins the pin
   wire [7:0] ulat_rd = upper_bus ? dbpm_pkg::READ_ONES :
                        ((ulat_reg & udir_reg) | (up_sync_reg & ~udir_reg));
   wire [7:0] llat_rd = lower_bus ? dbpm_pkg::READ_ONES :
                        ((llat_reg & ldir_reg) | (lo_sync_reg & ~ldir_reg));
   wire [7:0] rd_byte = (hit_udir || hit_ldir) ? dbpm_pkg::READ_ONES :
                        hit_ulat ? ulat_rd :
                        hit_llat ? llat_rd : 8'h00;

   // One wait state: data is captured at the same edge that pready rises
   logic        pready_next;
   logic [31:0] prdata_next;
   assign pready_next = acc_phase && !pready;
   assign prdata_next = rd_capture ? {24'h000000, rd_byte} : 32'h00000000;

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         pready  <= 1'b0;
         prdata  <= 32'h00000000;
         pslverr <= 1'b0;
      end else begin
         pready  <= pready_next;
         prdata  <= prdata_next;
         pslverr <= pready_next && !mapped;
      end
   end

   ////////////////////////////////////////////////////////////////////////////
   // Pin drive
   wire       drive_bus = bus_write_cycle && !sw_standby && !hws_reg;
   wire       gpio_on   = !hws_reg;
   wire [7:0] up_oe_nx  = upper_bus ? {8{drive_bus}} :
                          (gpio_on ? udir_reg : 8'h00);
   wire [7:0] lo_oe_nx  = lower_bus ? {8{drive_bus}} :
                          (gpio_on ? ldir_reg : 8'h00);
   // Bus lines carry only bus data, never the latch
   wire [7:0] up_out_nx = upper_bus ? bus_wdata[15:8] : ulat_reg;
   wire [7:0] lo_out_nx = lower_bus ? bus_wdata[7:0]  : llat_reg;

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         upper_pin_oe  <= 8'h00;
         upper_pin_out <= 8'h00;
         lower_pin_oe  <= 8'h00;
         lower_pin_out <= 8'h00;
         bus_rdata     <= 16'h0000;
      end else begin
         upper_pin_oe  <= up_oe_nx;
         upper_pin_out <= up_out_nx;
         lower_pin_oe  <= lo_oe_nx;
         lower_pin_out <= lo_out_nx;
         bus_rdata     <= {upper_bus ? up_sync_reg : 8'hff, lower_bus ? lo_sync_reg : 8'hff};
      end
   end

   ////////////////////////////////////////////////////////////////////////////
   // Checks
   default clocking cb @(posedge pclk); endclocking
   default disable iff (!presetn);

   a_dir_read_ones: assert property (
      acc_phase && !pready && !pwrite && (hit_udir || hit_ldir) |=> prdata[7:0] == 8'hff)
      else $error("direction read not all ones");
   a_udir_hw_clear: assert property (
      hws_reg |=> udir_reg == 8'h00 && ldir_reg == 8'h00)
      else $error("direction not cleared in hardware standby");
   a_latch_hw_clear: assert property (
      hws_reg |=> ulat_reg == 8'h00 && llat_reg == 8'h00)
      else $error("latch not cleared in hardware standby");
   a_sw_keep: assert property (
      sw_standby && !hws_reg && !(acc_phase && pwrite) |=> $stable(udir_reg) && $stable(ulat_reg))
      else $error("software standby changed registers");
   a_out_latch: assert property (
      !upper_bus && !hws_reg && udir_reg[0] |=> upper_pin_oe[0] && upper_pin_out[0] == $past(ulat_reg[0]))
      else $error("output pin not driving latch");
   a_in_float: assert property (
      !upper_bus && !udir_reg[3] |=> !upper_pin_oe[3])
      else $error("input pin driven");
   a_ulat_frozen: assert property (
      upper_bus && !hws_reg |=> ulat_reg == $past(ulat_reg))
      else $error("upper latch changed in bus mode");
   a_llat_frozen: assert property (
      lower_bus && !hws_reg |=> llat_reg == $past(llat_reg))
      else $error("lower latch changed in bus mode");
   a_bus_sw_float: assert property (
      upper_bus && sw_standby |=> upper_pin_oe == 8'h00)
      else $error("bus pins driven in software standby");
   a_lbus_drive: assert property (
      lower_bus && bus_write_cycle && !sw_standby && !hws_reg
      |=> lower_pin_oe == 8'hff && lower_pin_out == $past(bus_wdata[7:0]))
      else $error("lower bus not driving write data");
   a_apb_wait: assert property (
      acc_phase && !pready |=> pready ##1 !pready)
      else $error("ready not one cycle after access");
   // Ready and error timing
   a_ready_idle: assert property (
      !acc_phase |=> !pready && prdata == 32'h00000000)
      else $error("ready or read data outside an access");
   a_unmapped_err: assert property (
      acc_phase && !pready && !mapped |=> pready && pslverr && prdata == 32'h00000000)
      else $error("unmapped access not flagged");

   // Register writes land at the ready edge
   a_udir_write: assert property (
      wr_take && hit_udir && !hws_reg |=> udir_reg == $past(pwdata[7:0]))
      else $error("upper direction write lost");
   a_ldir_write: assert property (
      wr_take && hit_ldir && !hws_reg |=> ldir_reg == $past(pwdata[7:0]))
      else $error("lower direction write lost");
   a_ulat_write: assert property (
      wr_take && hit_ulat && !hws_reg && !upper_bus |=> ulat_reg == $past(pwdata[7:0]))
      else $error("upper latch write lost");
   a_llat_write: assert property (
      wr_take && hit_llat && !hws_reg && !lower_bus |=> llat_reg == $past(pwdata[7:0]))
      else $error("lower latch write lost");
   a_ulat_ones: assert property (
      rd_capture && hit_ulat && upper_bus |=> prdata[7:0] == 8'hff)
      else $error("upper latch read not all ones in bus mode");
   a_llat_ones: assert property (
      rd_capture && hit_llat && lower_bus |=> prdata[7:0] == 8'hff)
      else $error("lower latch read not all ones in bus mode");

   // Pin enables and bus read data per mode
   a_ugpio_oe: assert property (
      !upper_bus && !hws_reg |=> upper_pin_oe == $past(udir_reg))
      else $error("upper pin enable not following direction");
   a_lgpio_oe: assert property (
      !lower_bus && !hws_reg |=> lower_pin_oe == $past(ldir_reg))
      else $error("lower pin enable not following direction");
   a_ubus_drive: assert property (
      upper_bus && bus_write_cycle && !sw_standby && !hws_reg
      |=> upper_pin_oe == 8'hff && upper_pin_out == $past(bus_wdata[15:8]))
      else $error("upper bus not driving write data");
   a_ubus_release: assert property (
      upper_bus && !bus_write_cycle |=> upper_pin_oe == 8'h00)
      else $error("upper bus driven outside a write");
   a_lbus_release: assert property (
      lower_bus && !bus_write_cycle |=> lower_pin_oe == 8'h00)
      else $error("lower bus driven outside a write");
   a_lbus_sw_float: assert property (
      lower_bus && sw_standby |=> lower_pin_oe == 8'h00)
      else $error("lower bus driven in software standby");
   a_hw_float: assert property (
      hws_reg |=> upper_pin_oe == 8'h00 && lower_pin_oe == 8'h00)
      else $error("pins driven in hardware standby");
   a_ubus_rdata: assert property (
      upper_bus |=> bus_rdata[15:8] == $past(up_sync_reg))
      else $error("upper bus read data not pin level");
   a_lbus_rdata: assert property (
      lower_bus |=> bus_rdata[7:0] == $past(lo_sync_reg))
      else $error("lower bus read data not pin level");

   // Per-pin read path: output pins return the latch, input pins the pin
   for (genvar i = 0; i < 8; i++) begin : g_pin_chk
      a_uread_out: assert property (
         rd_capture && hit_ulat && !upper_bus && udir_reg[i] |=> prdata[i] == $past(ulat_reg[i]))
         else $error("upper output pin read not latch");
      a_uread_in: assert property (
         rd_capture && hit_ulat && !upper_bus && !udir_reg[i] |=> prdata[i] == $past(up_sync_reg[i]))
         else $error("upper input pin read not pin level");
      a_lread_out: assert property (
         rd_capture && hit_llat && !lower_bus && ldir_reg[i] |=> prdata[i] == $past(llat_reg[i]))
         else $error("lower output pin read not latch");
      a_lread_in: assert property (
         rd_capture && hit_llat && !lower_bus && !ldir_reg[i] |=> prdata[i] == $past(lo_sync_reg[i]))
         else $error("lower input pin read not pin level");
   end

   c_gpio_write: cover property (wr_take && hit_ulat && !upper_bus);
   c_bus_write:  cover property (upper_bus && bus_write_cycle ##1 upper_pin_oe == 8'hff);
   c_lower_gpio: cover property (mode_reg == dbpm_pkg::MODE_MIN2 && wr_take && hit_llat);
   c_unmapped:   cover property (pslverr);
   c_sw_float:   cover property (upper_bus && sw_standby && bus_write_cycle);

endmodule // dbpm_port

// ==== dbpm_bus_mem.sv ====
// Far side of the data bus: memory or peripheral answering on the port pins.
// Assumes the bench supplies the level that this side puts on undriven lines.
`timescale 1ns/1ps
module dbpm_bus_mem (
   // Level driven by the far side
   input  wire logic [15:0] far_val,
   // Port pins seen from outside
   input  wire logic [7:0]  upper_pin_out,
   input  wire logic [7:0]  upper_pin_oe,
   input  wire logic [7:0]  lower_pin_out,
   input  wire logic [7:0]  lower_pin_oe,
   output logic [7:0]       upper_pin_in,
   output logic [7:0]       lower_pin_in
);
   // Wire level: the port wins where it drives, else the far side drives
   assign upper_pin_in = (upper_pin_oe & upper_pin_out) | (~upper_pin_oe & far_val[15:8]);
   assign lower_pin_in = (lower_pin_oe & lower_pin_out) | (~lower_pin_oe & far_val[7:0]);
endmodule // dbpm_bus_mem

// ==== dual_bytewide_port_bus_mux_bench.sv ====
// Self-checking bench for the dual byte-wide port and bus mux.
// Assumes the design answers APB with pready and the far side model on the pins.
`timescale 1ns/1ps
module dual_bytewide_port_bus_mux_bench;
   logic        pclk = 1'b0, presetn = 1'b0, psel = 1'b0, penable = 1'b0, pwrite = 1'b0;
   logic [17:0] paddr = '0;
   logic [31:0] pwdata = '0, prdata, r;
   logic        pready, pslverr, err, hw_standby = 1'b0, sw_standby = 1'b0, bus_write_cycle = 1'b0, up_gp, lo_gp;
   logic [2:0]  mode_pins = 3'h7;
   logic [15:0] bus_wdata = '0, bus_rdata, far_val = 16'h5a3c, w;
   logic [7:0]  upper_pin_in, upper_pin_out, upper_pin_oe, lower_pin_in, lower_pin_out, lower_pin_oe, d, v;
   int          bad_count = 0, num_checks = 0, seed = 32'h23f35d00;
   wire [31:0]  oe_pair  = {16'h0000, upper_pin_oe, lower_pin_oe};
   wire [31:0]  out_pair = {16'h0000, upper_pin_out & upper_pin_oe, lower_pin_out & lower_pin_oe};
   always #10 pclk = ~pclk;
   dbpm_port dut (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite),
      .paddr(paddr), .pwdata(pwdata), .pready(pready), .prdata(prdata), .pslverr(pslverr),
      .mode_pins(mode_pins), .hw_standby(hw_standby), .sw_standby(sw_standby),
      .bus_write_cycle(bus_write_cycle), .bus_wdata(bus_wdata), .bus_rdata(bus_rdata),
      .upper_pin_in(upper_pin_in), .upper_pin_out(upper_pin_out), .upper_pin_oe(upper_pin_oe),
      .lower_pin_in(lower_pin_in), .lower_pin_out(lower_pin_out), .lower_pin_oe(lower_pin_oe));
   dbpm_bus_mem far (.far_val(far_val), .upper_pin_out(upper_pin_out), .upper_pin_oe(upper_pin_oe),
      .lower_pin_out(lower_pin_out), .lower_pin_oe(lower_pin_oe),
      .upper_pin_in(upper_pin_in), .lower_pin_in(lower_pin_in));
   ////////////////////////////////////////////////////////////////////////////
   task automatic report_and_stop();
      if (bad_count == 0 && num_checks > 0) $display("Result: passed");
      else $display("Result: failed");
      $finish;
   endtask
   task automatic chk(input logic [31:0] got, input logic [31:0] exp);
      num_checks++;
      if (got !== exp) begin
         bad_count++;
         $display("[FAIL] t=%0t got=%h exp=%h", $time, got, exp);
      end
   endtask
   task automatic apb(input logic wr, input logic [17:0] a, input logic [7:0] dv);
      int n;
      n = 0;
      psel <= 1'b1; pwrite <= wr; paddr <= a; pwdata <= {24'h0, dv};
      @(posedge pclk);
      penable <= 1'b1;
      do begin
         @(posedge pclk);
         n++;
      end while (pready !== 1'b1 && n < 20);
      r = prdata;
      err = pslverr;
      psel <= 1'b0; penable <= 1'b0;
      if (n >= 20) begin
         bad_count++;
         report_and_stop();
      end else begin
         @(posedge pclk);
      end
   endtask
   task automatic rd(input logic [17:0] a, input logic [7:0] e);
      apb(1'b0, a, 8'h00);
      chk(r, {24'h0, e});
   endtask
   task automatic tick(input int n);
      repeat (n) @(posedge pclk);
   endtask
   function automatic logic [7:0] exp_lat(input logic gp, input logic [7:0] dd, vv, p);
      return gp ? ((dd & vv) | (~dd & p)) : dbpm_pkg::READ_ONES;
   endfunction
   function automatic logic [31:0] pick(input logic ug, lg, input logic [15:0] g, b);
      return {16'h0000, ug ? g[15:8] : b[15:8], lg ? g[7:0] : b[7:0]};
   endfunction
   ////////////////////////////////////////////////////////////////////////////
   initial begin
      tick(2);
      presetn <= 1'b1;
      rd(dbpm_pkg::UPPER_DIR_ADDR, 8'hff);
      rd(dbpm_pkg::LOWER_DIR_ADDR, 8'hff);
      rd(dbpm_pkg::UPPER_LATCH_ADDR, far_val[15:8]);
      apb(1'b0, 18'h3fa10, 8'h00);
      chk(r, 32'h00000000);
      chk({31'h00000000, err}, 32'h00000001);
      for (int m = 1; m <= 7; m++) begin
         mode_pins <= m[2:0];
         far_val <= 16'($random(seed));
         d = 8'($random(seed));
         v = 8'($random(seed));
         w = 16'($random(seed));
         up_gp = (m == 7);
         lo_gp = (m == 7 || m == 2);
         tick(5);
         apb(1'b1, dbpm_pkg::UPPER_DIR_ADDR, d);
         apb(1'b1, dbpm_pkg::LOWER_DIR_ADDR, d);
         apb(1'b1, dbpm_pkg::UPPER_LATCH_ADDR, v);
         apb(1'b1, dbpm_pkg::LOWER_LATCH_ADDR, v);
         tick(2);
         chk(oe_pair, pick(up_gp, lo_gp, {d, d}, 16'h0000));
         bus_write_cycle <= 1'b1;
         bus_wdata <= w;
         tick(3);
         chk(oe_pair, pick(up_gp, lo_gp, {d, d}, 16'hffff));
         chk(out_pair, pick(up_gp, lo_gp, {d & v, d & v}, w));
         sw_standby <= 1'b1;
         tick(3);
         chk(oe_pair, pick(up_gp, lo_gp, {d, d}, 16'h0000));
         sw_standby <= 1'b0;
         bus_write_cycle <= 1'b0;
         tick(5);
         chk({16'h0000, bus_rdata}, pick(up_gp, lo_gp, 16'hffff, far_val));
         rd(dbpm_pkg::UPPER_LATCH_ADDR, exp_lat(up_gp, d, v, far_val[15:8]));
         rd(dbpm_pkg::LOWER_LATCH_ADDR, exp_lat(lo_gp, d, v, far_val[7:0]));
      end
      apb(1'b1, dbpm_pkg::UPPER_DIR_ADDR, 8'hff);
      apb(1'b1, dbpm_pkg::LOWER_DIR_ADDR, 8'hff);
      mode_pins <= 3'h1;
      tick(5);
      apb(1'b1, dbpm_pkg::UPPER_LATCH_ADDR, ~v);
      apb(1'b1, dbpm_pkg::LOWER_LATCH_ADDR, ~v);
      mode_pins <= 3'h7;
      tick(5);
      rd(dbpm_pkg::UPPER_LATCH_ADDR, v);
      rd(dbpm_pkg::LOWER_LATCH_ADDR, v);
      apb(1'b1, dbpm_pkg::LOWER_LATCH_ADDR, 8'ha5);
      hw_standby <= 1'b1;
      tick(4);
      hw_standby <= 1'b0;
      tick(4);
      chk(oe_pair, 32'h00000000);
      apb(1'b1, dbpm_pkg::UPPER_DIR_ADDR, 8'hff);
      apb(1'b1, dbpm_pkg::LOWER_DIR_ADDR, 8'hff);
      rd(dbpm_pkg::UPPER_LATCH_ADDR, dbpm_pkg::LATCH_RESET);
      rd(dbpm_pkg::LOWER_LATCH_ADDR, dbpm_pkg::LATCH_RESET);
      apb(1'b1, dbpm_pkg::LOWER_LATCH_ADDR, 8'h5a);
      presetn <= 1'b0;
      tick(2);
      presetn <= 1'b1;
      tick(4);
      chk(oe_pair, 32'h00000000);
      apb(1'b1, dbpm_pkg::LOWER_DIR_ADDR, 8'hff);
      rd(dbpm_pkg::LOWER_LATCH_ADDR, dbpm_pkg::LATCH_RESET);
      report_and_stop();
   end
endmodule // dual_bytewide_port_bus_mux_bench
